// ===== design/pixel_transfer_pkg.sv
// Purpose: shared constants and types of the pixel transfer datapath
// Assumes: colour, depth and real parameters are signed fixed point with FRAC_COLOR bits
// Notes:   parameter names are small codes on the parameter write port
package pixel_transfer_pkg;

    // ------------------------------------------------------------------
    // number formats
    // ------------------------------------------------------------------
    localparam int COLOR_W    = 16;
    localparam int FRAC_COLOR = 12;
    localparam int PARAM_W    = 24;
    localparam int INDEX_W    = 32;
    localparam int FRAC_INDEX = 4;
    localparam int ADDR_W     = 12;
    localparam int LOG_W      = 4;
    localparam int DATA_W     = 32;
    localparam int WIDE_W     = 48;
    localparam int CHANNELS   = 4;
    localparam int CH_DEPTH   = 4;

    localparam logic [COLOR_W-1:0]       COLOR_ONE  = 16'h1000;
    localparam logic signed [WIDE_W-1:0] UNIT_WIDE  = 48'sh000000001000;
    localparam logic [DATA_W-1:0]        ROUND_HALF = 32'h00000800;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [PARAM_W-1:0] GAIN_RESET   = 24'h001000;
    localparam logic [PARAM_W-1:0] OFFSET_RESET = 24'h000000;
    localparam logic [DATA_W-1:0]  INT_RESET    = 32'h00000000;

    // ------------------------------------------------------------------
    // parameter names
    // ------------------------------------------------------------------
    localparam logic [3:0] NAME_COLOR_LOOKUP   = 4'h0;
    localparam logic [3:0] NAME_STENCIL_LOOKUP = 4'h1;
    localparam logic [3:0] NAME_INDEX_SHIFT    = 4'h2;
    localparam logic [3:0] NAME_INDEX_OFFSET   = 4'h3;
    localparam logic [3:0] NAME_RED_GAIN       = 4'h4;
    localparam logic [3:0] NAME_DEPTH_OFFSET   = 4'hD;
    localparam logic [3:0] NAME_COUNT          = 4'hE;

    typedef enum logic [1:0] {
        KIND_COLOR,
        KIND_INDEX,
        KIND_DEPTH,
        KIND_STENCIL
    } pixel_kind_t;

endpackage : pixel_transfer_pkg

// ===== design/pixel_skid_buffer.sv
// Purpose: small flip-flop FIFO between the datapath and the receiver
// Assumes: one push and one pop per cycle at most
// Notes:   a stall by the receiver holds words until the buffer is full
module pixel_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // filling side
    input  wire logic             pushValid,
    output logic                  pushReady,
    input  wire logic [WIDTH-1:0] pushData,
    // draining side
    output logic                  popValid,
    input  wire logic             popReady,
    output logic [WIDTH-1:0]      popData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [CNT_W-1:0] count_r;
    wire              doPush = pushValid && pushReady;
    wire              doPop  = popValid && popReady;

    assign pushReady = (count_r != CNT_W'(DEPTH));
    assign popValid  = (count_r != '0);
    assign popData   = mem_r[rdPtr_r];

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doPush)
            begin
                mem_r[wrPtr_r] <= pushData;
                wrPtr_r        <= (wrPtr_r == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop)
                rdPtr_r <= (rdPtr_r == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            count_r <= count_r + CNT_W'(doPush) - CNT_W'(doPop);
        end
    end

endmodule : pixel_skid_buffer

// ===== design/pixel_transfer_datapath.sv
// Purpose: pixel transfer stage for colour, colour index, depth and stencil elements
// Assumes: tables are loaded elsewhere and read combinationally by address
// Notes:   one element per input handshake; results leave through a two-entry buffer

// Notes on behaviour
// - each colour component is multiplied by its own gain then its offset added
// - after gain and offset every colour component is clamped to zero through one
// - with colour lookup, component times table size indexes its table, result clamped
// - index shifted by signed amount, zero filled both ways, then offset added
// - index destinations keep indices; with lookup, mask low n bits and substitute
// - colour destinations mask index per channel, read four tables, clamp results
// - depth is multiplied by depth gain, offset added, clamped to zero through one
// - stencil shifted and offset like indices; with lookup, masked and substituted
// - the same fixed order of operations serves every pixel command
// - frame buffer pixels and unpacked client pixels both pass through the stage
// - colour is four normalised values, zero none and one full intensity
// - depth is one normalised value, zero minimum and one maximum depth
// - after reset lookups off, shift and offset zero, gains one, offsets zero
// - real-format write: zero is false for flags, integers rounded to nearest
// - integer write: zero is false for flags, value converted for real parameters
// - replayed commands use settings current when they run, not when recorded
// - unknown parameter name raises bad name error and changes nothing
// - writes of known names while a primitive is open raise bad sequence error and change nothing
module pixel_transfer_datapath (
    // clock and reset
    input  wire logic                                            clock,
    input  wire logic                                            nrst,
    // parameter writes
    input  wire logic                                            paramWrite,
    input  wire logic [3:0]                                      paramName,
    input  wire logic                                            paramIsReal,
    input  wire logic [pixel_transfer_pkg::DATA_W-1:0]           paramData,
    input  wire logic                                            primitiveOpen,
    output logic                                                 badNameError,
    output logic                                                 badSequenceError,
    // command framing
    input  wire logic                                            commandStart,
    // table sizes and reads
    input  wire logic [3:0][pixel_transfer_pkg::ADDR_W:0]        colorMapSize,
    output logic [3:0][pixel_transfer_pkg::ADDR_W-1:0]           colorMapAddr,
    input  wire logic [3:0][pixel_transfer_pkg::COLOR_W-1:0]     colorMapData,
    input  wire logic [3:0][pixel_transfer_pkg::LOG_W-1:0]       indexColorLog,
    output logic [3:0][pixel_transfer_pkg::ADDR_W-1:0]           indexColorAddr,
    input  wire logic [3:0][pixel_transfer_pkg::COLOR_W-1:0]     indexColorData,
    input  wire logic [pixel_transfer_pkg::LOG_W-1:0]            indexIndexLog,
    output logic [pixel_transfer_pkg::ADDR_W-1:0]                indexIndexAddr,
    input  wire logic [pixel_transfer_pkg::INDEX_W-1:0]          indexIndexData,
    input  wire logic [pixel_transfer_pkg::LOG_W-1:0]            stencilLog,
    output logic [pixel_transfer_pkg::ADDR_W-1:0]                stencilAddr,
    input  wire logic [pixel_transfer_pkg::INDEX_W-1:0]          stencilData,
    // input pixel stream
    input  wire logic                                            inValid,
    output logic                                                 inReady,
    input  wire pixel_transfer_pkg::pixel_kind_t                 inKind,
    input  wire logic                                            inAsIndex,
    input  wire logic                                            inFromFrameBuffer,
    input  wire logic [3:0][pixel_transfer_pkg::COLOR_W-1:0]     inColor,
    input  wire logic [pixel_transfer_pkg::INDEX_W-1:0]          inIndex,
    input  wire logic [pixel_transfer_pkg::COLOR_W-1:0]          inDepth,
    // output pixel stream
    output logic                                                 outValid,
    input  wire logic                                            outReady,
    output pixel_transfer_pkg::pixel_kind_t                      outKind,
    output logic                                                 outFromFrameBuffer,
    output logic [3:0][pixel_transfer_pkg::COLOR_W-1:0]          outColor,
    output logic [pixel_transfer_pkg::INDEX_W-1:0]               outIndex,
    output logic [pixel_transfer_pkg::COLOR_W-1:0]               outDepth
);
    localparam int CW   = pixel_transfer_pkg::COLOR_W;
    localparam int PW   = pixel_transfer_pkg::PARAM_W;
    localparam int IW   = pixel_transfer_pkg::INDEX_W;
    localparam int AW   = pixel_transfer_pkg::ADDR_W;
    localparam int WW   = pixel_transfer_pkg::WIDE_W;
    localparam int DW   = pixel_transfer_pkg::DATA_W;
    localparam int CF   = pixel_transfer_pkg::FRAC_COLOR;
    localparam int XF   = pixel_transfer_pkg::FRAC_INDEX;
    localparam int PKW  = 4 * CW + IW + CW + 3;
    localparam int DC   = pixel_transfer_pkg::CH_DEPTH;

    function automatic logic [CW-1:0] clampUnit(input logic signed [WW-1:0] v);
        if (v < 0)
            clampUnit = '0;
        else if (v > pixel_transfer_pkg::UNIT_WIDE)
            clampUnit = pixel_transfer_pkg::COLOR_ONE;
        else
            clampUnit = v[CW-1:0];
    endfunction : clampUnit

    // ------------------------------------------------------------------
    // parameter state: written copy and per-command copy
    // ------------------------------------------------------------------
    logic                 curColorLookup_r;
    logic                 curStencilLookup_r;
    logic signed [DW-1:0] curShift_r;
    logic signed [DW-1:0] curOffset_r;
    logic signed [PW-1:0] curGain_r [5];
    logic signed [PW-1:0] curBias_r [5];
    logic                 actColorLookup_r;
    logic                 actStencilLookup_r;
    logic signed [DW-1:0] actShift_r;
    logic signed [DW-1:0] actOffset_r;
    logic signed [PW-1:0] actGain_r [5];
    logic signed [PW-1:0] actBias_r [5];
    logic                 badName_r;
    logic                 badSequence_r;

    wire              nameOk     = paramName < pixel_transfer_pkg::NAME_COUNT;
    wire              writeOk    = paramWrite && nameOk && !primitiveOpen;
    wire              isRealName = paramName >= pixel_transfer_pkg::NAME_RED_GAIN;
    wire [3:0]        realSlot   = paramName - pixel_transfer_pkg::NAME_RED_GAIN;
    wire [2:0]        realCh     = realSlot[3:1];
    wire              isBias     = paramName[0];
    wire              flagValue  = paramData != '0;
    wire [DW-1:0]     roundedSum = paramData + pixel_transfer_pkg::ROUND_HALF;
    wire [DW-1:0]     roundedInt = DW'($signed(roundedSum) >>> CF);
    wire [DW-1:0]     intValue   = paramIsReal ? roundedInt : paramData;
    wire [DW-1:0]     liftedData = paramData << CF;
    wire [PW-1:0]     realValue  = paramIsReal ? paramData[PW-1:0] : liftedData[PW-1:0];

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            curColorLookup_r   <= 1'b0;
            curStencilLookup_r <= 1'b0;
            curShift_r         <= pixel_transfer_pkg::INT_RESET;
            curOffset_r        <= pixel_transfer_pkg::INT_RESET;
            for (int i = 0; i < 5; i++)
            begin
                curGain_r[i] <= pixel_transfer_pkg::GAIN_RESET;
                curBias_r[i] <= pixel_transfer_pkg::OFFSET_RESET;
            end
        end
        else if (writeOk)
        begin
            if (paramName == pixel_transfer_pkg::NAME_COLOR_LOOKUP)
                curColorLookup_r <= flagValue;
            if (paramName == pixel_transfer_pkg::NAME_STENCIL_LOOKUP)
                curStencilLookup_r <= flagValue;
            if (paramName == pixel_transfer_pkg::NAME_INDEX_SHIFT)
                curShift_r <= intValue;
            if (paramName == pixel_transfer_pkg::NAME_INDEX_OFFSET)
                curOffset_r <= intValue;
            if (isRealName && isBias)
                curBias_r[realCh] <= realValue;
            if (isRealName && !isBias)
                curGain_r[realCh] <= realValue;
        end
    end

    // a write in the same cycle as a command start reaches the next command
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            actColorLookup_r   <= 1'b0;
            actStencilLookup_r <= 1'b0;
            actShift_r         <= pixel_transfer_pkg::INT_RESET;
            actOffset_r        <= pixel_transfer_pkg::INT_RESET;
            for (int i = 0; i < 5; i++)
            begin
                actGain_r[i] <= pixel_transfer_pkg::GAIN_RESET;
                actBias_r[i] <= pixel_transfer_pkg::OFFSET_RESET;
            end
        end
        else if (commandStart)
        begin
            actColorLookup_r   <= curColorLookup_r;
            actStencilLookup_r <= curStencilLookup_r;
            actShift_r         <= curShift_r;
            actOffset_r        <= curOffset_r;
            actGain_r          <= curGain_r;
            actBias_r          <= curBias_r;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            badName_r     <= 1'b0;
            badSequence_r <= 1'b0;
        end
        else
        begin
            badName_r     <= paramWrite && !nameOk;
            badSequence_r <= paramWrite && nameOk && primitiveOpen;
        end
    end

    assign badNameError     = badName_r;
    assign badSequenceError = badSequence_r;

    // ------------------------------------------------------------------
    // index and stencil path
    // ------------------------------------------------------------------
    wire          shiftNeg   = actShift_r[DW-1];
    wire [DW-1:0] shiftMag   = shiftNeg ? DW'(-actShift_r) : actShift_r;
    wire          shiftAway  = shiftMag >= DW'(IW);
    wire [IW-1:0] shiftLeft  = inIndex << shiftMag[5:0];
    wire [IW-1:0] shiftRight = inIndex >> shiftMag[5:0];
    wire [IW-1:0] idxShifted = shiftAway ? '0 : (shiftNeg ? shiftRight : shiftLeft);
    wire [DW-1:0] offsetFix  = actOffset_r << XF;
    wire [IW-1:0] idxFinal   = idxShifted + offsetFix[IW-1:0];
    wire [IW-1:0] idxWhole   = IW'($signed(idxFinal) >>> XF);
    wire [AW-1:0] idxLow     = idxWhole[AW-1:0];

    assign indexIndexAddr = idxLow & ~({AW{1'b1}} << indexIndexLog);
    assign stencilAddr    = idxLow & ~({AW{1'b1}} << stencilLog);

    wire [IW-1:0] mappedIndex   = indexIndexData << XF;
    wire [IW-1:0] mappedStencil = stencilData << XF;
    wire          isIndex       = inKind == pixel_transfer_pkg::KIND_INDEX;
    wire          isStencil     = inKind == pixel_transfer_pkg::KIND_STENCIL;
    wire          indexToColor  = isIndex && !inAsIndex;
    wire [IW-1:0] indexResult   = (isIndex && actColorLookup_r) ? mappedIndex :
                                  (isStencil && actStencilLookup_r) ? mappedStencil :
                                  idxFinal;

    // ------------------------------------------------------------------
    // colour path, one lane per component
    // ------------------------------------------------------------------
    logic [3:0][CW-1:0] colorResult;

    for (genvar c = 0; c < pixel_transfer_pkg::CHANNELS; c++)
    begin : g_lane
        wire signed [WW-1:0] product  = WW'($signed(inColor[c])) * WW'(actGain_r[c]);
        wire signed [WW-1:0] biased   = (product >>> CF) + WW'(actBias_r[c]);
        wire [CW-1:0]        clamped  = clampUnit(biased);
        wire [DW-1:0]        sizeProd = DW'(clamped) * DW'(colorMapSize[c]);
        wire [DW-1:0]        lutPos   = (sizeProd + pixel_transfer_pkg::ROUND_HALF) >> CF;
        wire [DW-1:0]        lutTop   = DW'(colorMapSize[c]) - 1'b1;
        wire                 overTop  = (colorMapSize[c] == '0) || (lutPos > lutTop);
        wire [DW-1:0]        lutIdx   = (colorMapSize[c] == '0) ? '0 : (overTop ? lutTop : lutPos);
        wire [CW-1:0]        looked   = clampUnit(WW'($signed(colorMapData[c])));
        wire [CW-1:0]        fromIdx  = clampUnit(WW'($signed(indexColorData[c])));

        assign colorMapAddr[c]   = lutIdx[AW-1:0];
        assign indexColorAddr[c] = idxLow & ~({AW{1'b1}} << indexColorLog[c]);
        assign colorResult[c]    = indexToColor ? fromIdx :
                                   actColorLookup_r ? looked : clamped;
    end

    // ------------------------------------------------------------------
    // depth path
    // ------------------------------------------------------------------
    wire signed [WW-1:0] depthProd   = WW'($signed(inDepth)) * WW'(actGain_r[DC]);
    wire signed [WW-1:0] depthBiased = (depthProd >>> CF) + WW'(actBias_r[DC]);
    wire [CW-1:0]        depthResult = clampUnit(depthBiased);

    // ------------------------------------------------------------------
    // output buffer: the same order serves every source and command
    // ------------------------------------------------------------------
    pixel_transfer_pkg::pixel_kind_t resultKind;
    assign resultKind = indexToColor ? pixel_transfer_pkg::KIND_COLOR : inKind;

    wire [PKW-1:0] packedIn = {resultKind, inFromFrameBuffer, colorResult, indexResult, depthResult};
    wire [PKW-1:0] packedOut;

    pixel_skid_buffer #(
        .WIDTH (PKW),
        .DEPTH (2)
    ) u_buffer (
        .clock     (clock),
        .nrst      (nrst),
        .pushValid (inValid),
        .pushReady (inReady),
        .pushData  (packedIn),
        .popValid  (outValid),
        .popReady  (outReady),
        .popData   (packedOut)
    );

    assign outKind            = pixel_transfer_pkg::pixel_kind_t'(packedOut[PKW-1 -: 2]);
    assign outFromFrameBuffer = packedOut[PKW-3];
    assign outColor           = packedOut[IW+CW +: 4*CW];
    assign outIndex           = packedOut[CW +: IW];
    assign outDepth           = packedOut[CW-1:0];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_write_named;
        paramWrite && nameOk && !primitiveOpen;
    endsequence

    a_name_error_pulse: assert property (paramWrite && !nameOk |=> badNameError)
        else $error("bad name not flagged");
    a_seq_error_pulse: assert property (paramWrite && nameOk && primitiveOpen
        |=> badSequenceError && !badNameError)
        else $error("bad sequence not flagged");
    a_open_write_held: assert property (paramWrite && primitiveOpen
        |=> $stable(curShift_r) && $stable(curOffset_r) && $stable(curColorLookup_r))
        else $error("state changed inside primitive");
    a_shift_rounded: assert property (s_write_named
        ##0 (paramName == pixel_transfer_pkg::NAME_INDEX_SHIFT)
        |=> curShift_r == $past(intValue))
        else $error("shift not rounded as written");
    a_flag_truth: assert property (s_write_named
        ##0 (paramName == pixel_transfer_pkg::NAME_COLOR_LOOKUP)
        |=> curColorLookup_r == ($past(paramData) != '0))
        else $error("flag truth wrong");
    a_command_sample: assert property (commandStart ##1 !commandStart [*2]
        |-> actShift_r == $past(curShift_r, 2))
        else $error("settings not sampled at command start");
    a_color_unit_range: assert property (outValid
        && outKind == pixel_transfer_pkg::KIND_COLOR
        |-> outColor[0] <= pixel_transfer_pkg::COLOR_ONE
        && outColor[3] <= pixel_transfer_pkg::COLOR_ONE)
        else $error("colour outside unit range");
    a_depth_unit_range: assert property (outValid
        && outKind == pixel_transfer_pkg::KIND_DEPTH
        |-> outDepth <= pixel_transfer_pkg::COLOR_ONE)
        else $error("depth outside unit range");
    a_reset_gain: assert property (disable iff (1'b0) !nrst
        |=> curGain_r[0] == pixel_transfer_pkg::GAIN_RESET
        && !curColorLookup_r && curShift_r == '0)
        else $error("reset defaults wrong");

endmodule : pixel_transfer_datapath

// ===== testbench/pixel_table_model.sv
// Purpose: table store that faces the pixel transfer datapath
// Assumes: every table answers in the same cycle that its address is shown
// Notes:   entries follow their address, so a wrong address shows at the output
module pixel_table_model (
    // table sizes
    output logic [3:0][12:0]      colorMapSize,
    output logic [3:0][3:0]       indexColorLog,
    output logic [3:0]            indexIndexLog,
    output logic [3:0]            stencilLog,
    // table reads
    input  wire logic [3:0][11:0] colorMapAddr,
    output logic [3:0][15:0]      colorMapData,
    input  wire logic [3:0][11:0] indexColorAddr,
    output logic [3:0][15:0]      indexColorData,
    input  wire logic [11:0]      indexIndexAddr,
    output logic [31:0]           indexIndexData,
    input  wire logic [11:0]      stencilAddr,
    output logic [31:0]           stencilData
);
    timeunit 1ns;
    timeprecision 1ps;
    assign colorMapSize   = {4{13'h0100}};
    assign indexColorLog  = {4{4'h4}};
    assign indexIndexLog  = 4'h4;
    assign stencilLog     = 4'h4;
    assign indexIndexData = {20'h00000, indexIndexAddr};
    assign stencilData    = {20'h00000, stencilAddr};
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            colorMapData[i]   = {4'h0, colorMapAddr[i]};
            indexColorData[i] = {4'h0, indexColorAddr[i]};
        end
    end
endmodule : pixel_table_model

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the pixel transfer datapath
// Assumes: colour and depth are Q.12, indices carry 4 fraction bits
// Notes:   settings only take effect at the next command start
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, nrst, paramWrite, paramIsReal, primitiveOpen, commandStart, badNameError;
    logic badSequenceError, inValid, inReady, inAsIndex, inFromFrameBuffer;
    logic outValid, outReady, outFromFrameBuffer;
    logic [3:0]       paramName, indexIndexLog, stencilLog;
    logic [31:0]      paramData, inIndex, outIndex, indexIndexData, stencilData;
    logic [15:0]      inDepth, outDepth;
    logic [11:0]      indexIndexAddr, stencilAddr;
    logic [3:0][15:0] inColor, outColor, colorMapData, indexColorData;
    logic [3:0][11:0] colorMapAddr, indexColorAddr;
    logic [3:0][12:0] colorMapSize;
    logic [3:0][3:0]  indexColorLog;
    pixel_transfer_pkg::pixel_kind_t inKind, outKind;
    int failures = 0, samples_checked = 0, cycles = 0;
    pixel_transfer_datapath dut (.clock, .nrst, .paramWrite, .paramName, .paramIsReal,
        .paramData, .primitiveOpen, .badNameError, .badSequenceError, .commandStart,
        .colorMapSize, .colorMapAddr, .colorMapData, .indexColorLog, .indexColorAddr,
        .indexColorData, .indexIndexLog, .indexIndexAddr, .indexIndexData, .stencilLog,
        .stencilAddr, .stencilData, .inValid, .inReady, .inKind, .inAsIndex,
        .inFromFrameBuffer, .inColor, .inIndex, .inDepth, .outValid, .outReady, .outKind,
        .outFromFrameBuffer, .outColor, .outIndex, .outDepth);
    pixel_table_model tables (.colorMapSize, .indexColorLog, .indexIndexLog, .stencilLog,
        .colorMapAddr, .colorMapData, .indexColorAddr, .indexColorData, .indexIndexAddr,
        .indexIndexData, .stencilAddr, .stencilData);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [3:0] n, input logic r, input logic [31:0] d, input logic eN,
                      input logic eS);
        @(posedge clock);
        {paramWrite, paramName, paramIsReal, paramData} <= {1'b1, n, r, d};
        @(posedge clock);
        paramWrite <= 1'b0;
        @(negedge clock);
        chk(badNameError, eN);
        chk(badSequenceError, eS);
    endtask : wr
    task automatic cs;
        @(posedge clock);
        commandStart <= 1'b1;
        @(posedge clock);
        commandStart <= 1'b0;
    endtask : cs
    task automatic send(input pixel_transfer_pkg::pixel_kind_t k, input logic a, input logic f,
                        input logic [63:0] c, input logic [31:0] i, input logic [15:0] d);
        @(posedge clock);
        inKind <= k;
        {inValid, inAsIndex, inFromFrameBuffer, inColor, inIndex, inDepth} <= {1'b1, a, f, c, i, d};
        @(negedge clock);
        while (inReady !== 1'b1)
            @(negedge clock);
        @(posedge clock);
        inValid <= 1'b0;
    endtask : send
    task automatic get(input int w, input logic [63:0] e, input logic f);
        @(negedge clock);
        while (outValid !== 1'b1)
            @(negedge clock);
        chk(w == 0 ? outColor : (w == 2 ? 64'(outDepth) : 64'(outIndex)), e);
        chk(outKind, w[1:0]);
        chk(outFromFrameBuffer, f);
        @(posedge clock);
    endtask : get
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // a hang counts as a mismatch
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        {nrst, paramWrite, paramName, paramIsReal, paramData, primitiveOpen, commandStart} = '0;
        {inValid, inAsIndex, inFromFrameBuffer, inColor, inIndex, inDepth} = '0;
        inKind = pixel_transfer_pkg::KIND_COLOR;
        outReady = 1'b1;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        send(pixel_transfer_pkg::KIND_COLOR, 0, 1, {4{16'h0800}}, 0, 0);
        get(0, {4{16'h0800}}, 1);
        wr(4'h4, 0, 2, 0, 0);
        send(pixel_transfer_pkg::KIND_COLOR, 0, 0, {4{16'h0C00}}, 0, 0);
        get(0, {4{16'h0C00}}, 0);
        cs();
        send(pixel_transfer_pkg::KIND_COLOR, 0, 1, {4{16'h0C00}}, 0, 0);
        get(0, {{3{16'h0C00}}, 16'h1000}, 1);
        wr(4'hE, 0, 0, 1, 0);
        @(posedge clock) primitiveOpen <= 1'b1;
        wr(4'h4, 0, 0, 0, 1);
        @(posedge clock) primitiveOpen <= 1'b0;
        cs();
        send(pixel_transfer_pkg::KIND_COLOR, 0, 0, {4{16'h0C00}}, 0, 0);
        get(0, {{3{16'h0C00}}, 16'h1000}, 0);
        wr(4'h2, 1, 32'h00001800, 0, 0);
        wr(4'h3, 0, 3, 0, 0);
        cs();
        send(pixel_transfer_pkg::KIND_INDEX, 1, 0, 0, 32'h00000010, 0);
        get(1, 32'h00000070, 0);
        send(pixel_transfer_pkg::KIND_STENCIL, 0, 1, 0, 32'h00000010, 0);
        get(3, 32'h00000070, 1);
        wr(4'h2, 0, 32'hFFFFFFFF, 0, 0);
        wr(4'hD, 1, 32'h00000400, 0, 0);
        cs();
        send(pixel_transfer_pkg::KIND_INDEX, 1, 0, 0, 32'h00000010, 0);
        get(1, 32'h00000038, 0);
        send(pixel_transfer_pkg::KIND_DEPTH, 0, 0, 0, 0, 16'h0200);
        get(2, 16'h0600, 0);
        send(pixel_transfer_pkg::KIND_DEPTH, 0, 1, 0, 0, 16'h0E00);
        get(2, 16'h1000, 1);
        wr(4'h0, 1, 32'h00000800, 0, 0);
        wr(4'h1, 0, 7, 0, 0);
        cs();
        send(pixel_transfer_pkg::KIND_INDEX, 1, 0, 0, 32'h00000010, 0);
        get(1, 32'h00000030, 0);
        send(pixel_transfer_pkg::KIND_INDEX, 0, 0, 0, 32'h00000010, 0);
        get(0, {4{16'h0003}}, 0);
        send(pixel_transfer_pkg::KIND_STENCIL, 0, 1, 0, 32'h00000010, 0);
        get(3, 32'h00000030, 1);
        // receiver stalls while two words fill the buffer
        @(posedge clock) outReady <= 1'b0;
        send(pixel_transfer_pkg::KIND_COLOR, 0, 1, {4{16'h0800}}, 0, 0);
        send(pixel_transfer_pkg::KIND_COLOR, 0, 0, {4{16'h0800}}, 0, 0);
        @(negedge clock) chk(inReady, 1'b0);
        @(posedge clock) outReady <= 1'b1;
        get(0, {{3{16'h0080}}, 16'h00FF}, 1);
        get(0, {{3{16'h0080}}, 16'h00FF}, 0);
        print_verdict();
    end
endmodule : tb_top
